// *** hdl/wgr_pkg.sv ***
// Package: constants and carrier types for the web guide remote command block
package wgr_pkg;

    // ---------------------------------------------------------------
    // Register word selects on the write port
    // ---------------------------------------------------------------
    localparam logic [1:0] ADDR_COMMAND = 2'h0;
    localparam logic [1:0] ADDR_OFFSET  = 2'h1;
    localparam logic [1:0] ADDR_SPEED   = 2'h2;
    localparam logic [1:0] ADDR_ACCEL   = 2'h3;

    // ---------------------------------------------------------------
    // Command word bit positions
    // ---------------------------------------------------------------
    localparam int BIT_REMOTE   = 8;
    localparam int BIT_AUTO     = 9;
    localparam int BIT_RIGHT    = 11;
    localparam int BIT_CENTER   = 12;
    localparam int BIT_GROSS_EN = 13;

    // ---------------------------------------------------------------
    // Speed and acceleration word fields
    // ---------------------------------------------------------------
    localparam int SPD_EN_BIT = 15;
    localparam int SPD_LSB    = 8;
    localparam int ACC_EN_BIT = 7;
    localparam int ACC_LSB    = 0;
    localparam int SET_W      = 7;
    localparam logic [6:0] SET_MAX = 7'h64;

    // ---------------------------------------------------------------
    // Guide point units: one unit = 0.0635 mm (1/400 inch)
    // ---------------------------------------------------------------
    localparam real UNIT_MM      = 0.0635;
    localparam real STEP_MM      = 0.254;
    localparam real MARGIN_MM    = 3.175;
    // Cast rounds to nearest already, so no half is added
    localparam int  STEP_UNITS   = int'(STEP_MM / UNIT_MM);
    localparam int  MARGIN_UNITS = int'(MARGIN_MM / UNIT_MM);

    // Reset values
    localparam logic [15:0] CMD_RST   = 16'h0000;
    localparam logic [6:0]  SPEED_RST = 7'h32;
    localparam logic [6:0]  ACCEL_RST = 7'h32;

    // Write port bundle
    typedef struct packed {
        logic        wr;
        logic [1:0]  addr;
        logic [15:0] data;
    } wgr_wr_type;

    // Manual motion requests
    typedef struct packed {
        logic jog_right;
        logic center_start;
    } wgr_motion_type;

    // Automatic guide point operations
    typedef enum logic [1:0] {
        GP_NONE  = 2'b00,
        GP_STEP  = 2'b01,
        GP_MID   = 2'b10,
        GP_GROSS = 2'b11
    } wgr_gp_op_type;

endpackage

// *** hdl/wgr_setting.sv ***
// Gated register for one 7-bit actuator setting word
`timescale 1ns/1ps
module wgr_setting #(
    parameter int          LSB     = 0,
    parameter int          EN_BIT  = 7,
    parameter logic [6:0]  RST_VAL = 7'h00,
    parameter logic [6:0]  MAX_VAL = 7'h64
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr_sel,
    input  wire logic [15:0] wr_data,
    output logic [6:0]       value_q
);
    logic [6:0] field;

    assign field = wr_data[LSB +: 7];

    // Update only with enable bit set and legal value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_q <= RST_VAL;
        end else if (wr_sel && wr_data[EN_BIT] && field <= MAX_VAL) begin
            value_q <= field;
        end
    end

    chk_gated_update: assert property (@(posedge clk) disable iff (rst)
        (wr_sel && !wr_data[EN_BIT]) |=> $stable(value_q))
        else $error("setting changed without enable bit");
endmodule

// *** hdl/wgr_clamp.sv ***
// Guide point clamp to the window with travel margin
`timescale 1ns/1ps
module wgr_clamp #(
    parameter int GP_W = 18
) (
    input  wire logic signed [GP_W-1:0] value,
    input  wire logic signed [GP_W-1:0] lo,
    input  wire logic signed [GP_W-1:0] hi,
    output logic signed [GP_W-1:0]      result
);
    // Clip to the nearer limit
    always_comb begin
        if (value < lo) begin
            result = lo;
        end else if (value > hi) begin
            result = hi;
        end else begin
            result = value;
        end
    end
endmodule

// *** hdl/wgr_top.sv ***
// Web guide remote command decoder
//
// Functional notes
// - Manual mode: bit 11 one starts jog right, zero stops it.
// - Jog right state changes only by writes, not at travel end.
// - Auto mode: bit 11 rising raises guide point by 0.254 mm unless bit 12 rises in the same write.
// - Any guide point change is clipped to the window limits.
// - Manual mode: bit 12 rising starts servo centre; zero does nothing.
// - Servo centre bit keeps written value when centre is reached.
// - Auto mode: bit 12 rising sets guide point to window middle.
// - Limits keep 3.175 mm travel on both sides of guide point if the window is 6.35 mm or more; narrower windows pin it to the middle.
// - Bit 13 enables gross guide point positioning by signed offset.
// - Offset word applied only while bit 13 is one.
// - Positive offset moves right, negative moves left, from middle.
// - One offset unit is 0.0635 mm.
// - Speed takes bits 14..8 only when bit 15 set, range 0..100.
// - Accel takes bits 6..0 only when bit 7 set, range 0..100.
// - Bit 9 selects manual (0) or automatic (1) mode.
// - Bit 8 hands control to the remote controller.
`timescale 1ns/1ps
module wgr_top #(
    parameter int GP_W = 18
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire wgr_pkg::wgr_wr_type    wr,
    input  wire logic [GP_W-2:0]        window_units,
    output logic                        remote_ctrl,
    output logic                        auto_mode,
    output wgr_pkg::wgr_motion_type     motion,
    output logic                        gross_en,
    output logic signed [GP_W-1:0]      guide_point_q,
    output logic                        gp_update,
    output wgr_pkg::wgr_gp_op_type      gp_op,
    output logic [6:0]                  speed_q,
    output logic [6:0]                  accel_q
);
    // ---------------------------------------------------------------
    // Decoded write strobes
    // ---------------------------------------------------------------
    logic        cmd_we;
    logic        off_we;
    logic        spd_we;
    logic        acc_we;
    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic        jog_q;
    logic        center_q;
    logic [6:0]  spd_field;
    logic [6:0]  acc_field;

    assign cmd_we = wr.wr && wr.addr == wgr_pkg::ADDR_COMMAND;
    assign off_we = wr.wr && wr.addr == wgr_pkg::ADDR_OFFSET;
    assign spd_we = wr.wr && wr.addr == wgr_pkg::ADDR_SPEED;
    assign acc_we = wr.wr && wr.addr == wgr_pkg::ADDR_ACCEL;

    // Reserved bits dropped before storing
    assign cmd_d = {2'b00, wr.data[13:8], 8'h00};

    // ---------------------------------------------------------------
    // Command word store, changed only by writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_q <= wgr_pkg::CMD_RST;
        end else if (cmd_we) begin
            cmd_q <= cmd_d;
        end
    end

    // Setting fields, watched by the checks
    assign spd_field = wr.data[wgr_pkg::SPD_LSB +: wgr_pkg::SET_W];
    assign acc_field = wr.data[wgr_pkg::ACC_LSB +: wgr_pkg::SET_W];

    assign remote_ctrl = cmd_q[wgr_pkg::BIT_REMOTE];
    assign auto_mode   = cmd_q[wgr_pkg::BIT_AUTO];
    assign gross_en    = cmd_q[wgr_pkg::BIT_GROSS_EN];

    // ---------------------------------------------------------------
    // Edge detection against previously written value
    // ---------------------------------------------------------------
    logic rise_right;
    logic rise_center;
    logic wr_auto;

    assign wr_auto     = cmd_d[wgr_pkg::BIT_AUTO];
    assign rise_right  = cmd_we && cmd_d[wgr_pkg::BIT_RIGHT] && !cmd_q[wgr_pkg::BIT_RIGHT];
    assign rise_center = cmd_we && cmd_d[wgr_pkg::BIT_CENTER] && !cmd_q[wgr_pkg::BIT_CENTER];

    // ---------------------------------------------------------------
    // Manual motion outputs
    // ---------------------------------------------------------------
    // Jog level follows stored bit in manual mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            jog_q <= 1'b0;
        end else if (cmd_we) begin
            jog_q <= !wr_auto && cmd_d[wgr_pkg::BIT_RIGHT];
        end
    end

    // Centre start pulse on rising bit in manual mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            center_q <= 1'b0;
        end else begin
            center_q <= rise_center && !wr_auto;
        end
    end

    // Both motion requests leave as one bundle
    assign motion = '{jog_right: jog_q, center_start: center_q};

    // ---------------------------------------------------------------
    // Guide point limits, in offset units from window middle
    // ---------------------------------------------------------------
    localparam logic signed [GP_W-1:0] STEP   = GP_W'(wgr_pkg::STEP_UNITS);
    localparam logic signed [GP_W-1:0] MARGIN = GP_W'(wgr_pkg::MARGIN_UNITS);

    logic signed [GP_W-1:0] half_w;
    logic signed [GP_W-1:0] lim_hi;
    logic signed [GP_W-1:0] lim_lo;
    logic signed [GP_W-1:0] gp_target;
    logic signed [GP_W-1:0] gp_clip;
    logic signed [GP_W-1:0] offset_ext;

    assign half_w     = signed'({2'b00, window_units[GP_W-2:1]});
    assign lim_hi     = (half_w > MARGIN) ? half_w - MARGIN : '0;
    assign lim_lo     = -lim_hi;
    assign offset_ext = GP_W'(signed'(wr.data));

    // ---------------------------------------------------------------
    // Guide point operation select: step and middle in automatic mode, gross offset in either mode
    // ---------------------------------------------------------------
    wgr_pkg::wgr_gp_op_type op_d;

    always_comb begin
        op_d = wgr_pkg::GP_NONE;
        if (cmd_we && wr_auto && rise_center) begin
            op_d = wgr_pkg::GP_MID;
        end else if (cmd_we && wr_auto && rise_right) begin
            op_d = wgr_pkg::GP_STEP;
        end else if (gross_en && off_we) begin
            op_d = wgr_pkg::GP_GROSS;
        end
    end

    // Target before clipping
    always_comb begin
        case (op_d)
            wgr_pkg::GP_STEP: begin
                gp_target = guide_point_q + STEP;
            end
            wgr_pkg::GP_MID: begin
                gp_target = '0;
            end
            wgr_pkg::GP_GROSS: begin
                gp_target = offset_ext;
            end
            default: begin
                gp_target = guide_point_q;
            end
        endcase
    end

    wgr_clamp #(
        .GP_W (GP_W)
    ) u_clamp (
        .value  (gp_target),
        .lo     (lim_lo),
        .hi     (lim_hi),
        .result (gp_clip)
    );

    // Guide point register and update pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            guide_point_q <= '0;
            gp_update     <= 1'b0;
            gp_op         <= wgr_pkg::GP_NONE;
        end else begin
            gp_update <= op_d != wgr_pkg::GP_NONE;
            gp_op     <= op_d;
            if (op_d != wgr_pkg::GP_NONE) begin
                guide_point_q <= gp_clip;
            end
        end
    end

    // ---------------------------------------------------------------
    // Actuator settings
    // ---------------------------------------------------------------
    wgr_setting #(
        .LSB     (wgr_pkg::SPD_LSB),
        .EN_BIT  (wgr_pkg::SPD_EN_BIT),
        .RST_VAL (wgr_pkg::SPEED_RST),
        .MAX_VAL (wgr_pkg::SET_MAX)
    ) u_speed (
        .clk     (clk),
        .rst     (rst),
        .wr_sel  (spd_we),
        .wr_data (wr.data),
        .value_q (speed_q)
    );

    wgr_setting #(
        .LSB     (wgr_pkg::ACC_LSB),
        .EN_BIT  (wgr_pkg::ACC_EN_BIT),
        .RST_VAL (wgr_pkg::ACCEL_RST),
        .MAX_VAL (wgr_pkg::SET_MAX)
    ) u_accel (
        .clk     (clk),
        .rst     (rst),
        .wr_sel  (acc_we),
        .wr_data (wr.data),
        .value_q (accel_q)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_jog_follows: assert property (@(posedge clk) disable iff (rst)
        (cmd_we && !wr.data[wgr_pkg::BIT_AUTO]) |=> (motion.jog_right == $past(wr.data[wgr_pkg::BIT_RIGHT])))
        else $error("jog right does not follow command bit");

    chk_cmd_hold: assert property (@(posedge clk) disable iff (rst)
        !cmd_we |=> $stable(cmd_q))
        else $error("command word changed without write");

    chk_step_size: assert property (@(posedge clk) disable iff (rst)
        (op_d == wgr_pkg::GP_STEP && guide_point_q + STEP <= lim_hi) |=>
        (guide_point_q == $past(guide_point_q) + STEP))
        else $error("step did not add one step");

    chk_within_limits: assert property (@(posedge clk) disable iff (rst)
        gp_update |-> (guide_point_q <= lim_hi && guide_point_q >= lim_lo))
        else $error("guide point outside limits");

    chk_center_pulse: assert property (@(posedge clk) disable iff (rst)
        motion.center_start |=> !motion.center_start)
        else $error("centre start longer than one cycle");

    chk_mid_zero: assert property (@(posedge clk) disable iff (rst)
        (gp_op == wgr_pkg::GP_MID) |-> (guide_point_q == 0))
        else $error("midpoint not zero");

    chk_gross_gate: assert property (@(posedge clk) disable iff (rst)
        (off_we && !gross_en && !cmd_we) |=> $stable(guide_point_q))
        else $error("offset applied while gross disabled");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        cmd_q[15:14] == 2'b00 && cmd_q[7:0] == 8'h00)
        else $error("reserved command bits stored");

    // Auto-mode write never leaves jog running
    chk_jog_auto_off: assert property (@(posedge clk) disable iff (rst)
        (cmd_we && wr.data[wgr_pkg::BIT_AUTO]) |=> !motion.jog_right)
        else $error("jog right left on by auto mode write");

    // Jog level moves only on a command write
    chk_jog_no_write: assert property (@(posedge clk) disable iff (rst)
        !cmd_we |=> $stable(motion.jog_right))
        else $error("jog right changed without write");

    // Command write without a rising bit gives no guide point change
    chk_step_once: assert property (@(posedge clk) disable iff (rst)
        (cmd_we && !rise_right && !rise_center) |=> !gp_update)
        else $error("guide point changed without rising bit");

    // No write at all, no guide point change
    chk_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        (!cmd_we && !off_we) |=> !gp_update)
        else $error("guide point changed without write");

    // Servo centre only in manual mode
    chk_center_auto_off: assert property (@(posedge clk) disable iff (rst)
        (cmd_we && wr.data[wgr_pkg::BIT_AUTO]) |=> !motion.center_start)
        else $error("centre start in auto mode");

    // Servo centre needs a rising bit
    chk_center_needs_rise: assert property (@(posedge clk) disable iff (rst)
        !rise_center |=> !motion.center_start)
        else $error("centre start without rising bit");

    // Stored centre bit is the written one
    chk_center_keep: assert property (@(posedge clk) disable iff (rst)
        cmd_we |=> (cmd_q[wgr_pkg::BIT_CENTER] == $past(wr.data[wgr_pkg::BIT_CENTER])))
        else $error("centre bit differs from written value");

    // Margin left on both sides of a new guide point other than the middle
    chk_margin_kept: assert property (@(posedge clk) disable iff (rst)
        gp_update |-> (guide_point_q == 0 ||
                       (guide_point_q + MARGIN <= half_w && guide_point_q - MARGIN >= -half_w)))
        else $error("travel margin not kept");

    // In-range offset lands unchanged
    chk_gross_value: assert property (@(posedge clk) disable iff (rst)
        (op_d == wgr_pkg::GP_GROSS && offset_ext <= lim_hi && offset_ext >= lim_lo) |=>
        (guide_point_q == $past(offset_ext)))
        else $error("gross offset not applied as written");

    // Enabled gross offset write always acts
    chk_gross_applies: assert property (@(posedge clk) disable iff (rst)
        (off_we && gross_en) |=> gp_update)
        else $error("enabled offset write ignored");

    // Step past the top stops at the limit
    chk_step_clip: assert property (@(posedge clk) disable iff (rst)
        (op_d == wgr_pkg::GP_STEP && guide_point_q + STEP > lim_hi) |=>
        (guide_point_q == $past(lim_hi)))
        else $error("step not clipped to limit");

    // Mode follows the written mode bit
    chk_mode_bit: assert property (@(posedge clk) disable iff (rst)
        cmd_we |=> (auto_mode == $past(wr.data[wgr_pkg::BIT_AUTO])))
        else $error("mode differs from written bit");

    // Remote control follows the written bit
    chk_remote_bit: assert property (@(posedge clk) disable iff (rst)
        cmd_we |=> (remote_ctrl == $past(wr.data[wgr_pkg::BIT_REMOTE])))
        else $error("remote control differs from written bit");

    // Speed never leaves its legal range
    chk_speed_legal: assert property (@(posedge clk) disable iff (rst)
        speed_q <= wgr_pkg::SET_MAX)
        else $error("speed above range");

    // Acceleration never leaves its legal range
    chk_accel_legal: assert property (@(posedge clk) disable iff (rst)
        accel_q <= wgr_pkg::SET_MAX)
        else $error("acceleration above range");

    // Enabled legal speed is taken
    chk_speed_take: assert property (@(posedge clk) disable iff (rst)
        (spd_we && wr.data[wgr_pkg::SPD_EN_BIT] && spd_field <= wgr_pkg::SET_MAX) |=>
        (speed_q == $past(spd_field)))
        else $error("enabled speed not taken");

    // Enabled legal acceleration is taken
    chk_accel_take: assert property (@(posedge clk) disable iff (rst)
        (acc_we && wr.data[wgr_pkg::ACC_EN_BIT] && acc_field <= wgr_pkg::SET_MAX) |=>
        (accel_q == $past(acc_field)))
        else $error("enabled acceleration not taken");

    cov_step: cover property (@(posedge clk) disable iff (rst) op_d == wgr_pkg::GP_STEP);
    cov_mid: cover property (@(posedge clk) disable iff (rst) op_d == wgr_pkg::GP_MID);
    cov_gross: cover property (@(posedge clk) disable iff (rst) op_d == wgr_pkg::GP_GROSS);
    cov_center: cover property (@(posedge clk) disable iff (rst) motion.center_start);
    cov_clip: cover property (@(posedge clk) disable iff (rst) gp_update && guide_point_q == lim_hi);
endmodule

// *** tb/wgr_ctrl_model.sv ***
// Remote network controller model that writes command and setting words
`timescale 1ns/1ps
module wgr_ctrl_model (
    input  wire logic            clk,
    output wgr_pkg::wgr_wr_type  wr
);
    // ---------------------------------------------------------------
    // Idle state
    // ---------------------------------------------------------------
    initial begin
        wr = '0;
    end

    // ---------------------------------------------------------------
    // One write per call, strobe held for one taking edge
    // ---------------------------------------------------------------
    // Callers may resend a momentary bit without clearing it, and then it does not act again
    // Settings are also sent enabled with value 101, which must be rejected
    task automatic send(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= '{wr: 1'b1, addr: a, data: d};
        @(posedge clk);
        // Released lines no longer show the last word
        wr <= '{wr: 1'b0, addr: ~a, data: ~d};
    endtask
endmodule

// *** tb/web_guide_remote_command_test.sv ***
// Self-checking bench for the web guide remote command decoder
`timescale 1ns/1ps
module web_guide_remote_command_test;
    logic                          clk;
    logic                          rst;
    wgr_pkg::wgr_wr_type           wr;
    logic                          remote_ctrl;
    logic                          auto_mode;
    wgr_pkg::wgr_motion_type       motion;
    logic                          gross_en;
    logic signed [17:0]            gp;
    logic                          gp_update;
    wgr_pkg::wgr_gp_op_type        gp_op;
    logic [6:0]                    speed_q;
    logic [6:0]                    accel_q;
    logic [16:0]                   window;
    int                            fails;
    int                            n_checks;

    // ---------------------------------------------------------------
    // Clock, reset, instances
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Window of 400 units gives limits of +/-150
    wgr_top uut (.clk(clk), .rst(rst), .wr(wr), .window_units(window), .remote_ctrl(remote_ctrl),
                 .auto_mode(auto_mode), .motion(motion), .gross_en(gross_en), .guide_point_q(gp),
                 .gp_update(gp_update), .gp_op(gp_op), .speed_q(speed_q), .accel_q(accel_q));

    wgr_ctrl_model ctrl (.clk(clk), .wr(wr));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpb(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write one word, then let the answering edge settle
    task automatic put(input logic [1:0] a, input logic [15:0] d);
        ctrl.send(a, d);
        #1;
    endtask

    // Write, then check guide point, update pulse and op code
    task automatic gp_chk(input logic [1:0] a, input logic [15:0] d, input logic [17:0] e, input logic u,
                          input logic [1:0] op);
        put(a, d);
        cmp(gp, e);
        cmpb(gp_update, u);
        cmp({16'h0000, gp_op}, {16'h0000, op});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        fails = 0;
        n_checks = 0;
        window = 17'h00190;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp({11'h000, speed_q}, 18'h00032);
        cmp({11'h000, accel_q}, 18'h00032);
        cmp(gp, 18'h00000);
        // Manual jog right starts, holds, stops
        put(wgr_pkg::ADDR_COMMAND, 16'h0900);
        cmpb(remote_ctrl, 1'b1);
        cmpb(auto_mode, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        cmpb(motion.jog_right, 1'b1);
        put(wgr_pkg::ADDR_COMMAND, 16'h0100);
        cmpb(motion.jog_right, 1'b0);
        // Manual servo centre pulse, then a clear that gives no pulse
        put(wgr_pkg::ADDR_COMMAND, 16'h1000);
        cmpb(motion.center_start, 1'b1);
        @(posedge clk);
        #1;
        cmpb(motion.center_start, 1'b0);
        put(wgr_pkg::ADDR_COMMAND, 16'h0000);
        cmpb(motion.center_start, 1'b0);
        // Automatic steps act on rising edges only
        put(wgr_pkg::ADDR_COMMAND, 16'h0200);
        cmpb(auto_mode, 1'b1);
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'h0A00, 18'h00004, 1'b1, 2'h1);
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'h0A00, 18'h00004, 1'b0, 2'h0);
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'h0200, 18'h00004, 1'b0, 2'h0);
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'h0A00, 18'h00008, 1'b1, 2'h1);
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'h1200, 18'h00000, 1'b1, 2'h2);
        // Gross positioning with signed offsets and clipping
        put(wgr_pkg::ADDR_COMMAND, 16'h2200);
        cmpb(gross_en, 1'b1);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'h0064, 18'h00064, 1'b1, 2'h3);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'hFFF0, 18'h3FFF0, 1'b1, 2'h3);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'h7FFF, 18'h00096, 1'b1, 2'h3);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'h8000, 18'h3FF6A, 1'b1, 2'h3);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'h0096, 18'h00096, 1'b1, 2'h3);
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'h2A00, 18'h00096, 1'b1, 2'h1);
        // Offset ignored once gross adjustment is off
        put(wgr_pkg::ADDR_COMMAND, 16'h0200);
        cmpb(gross_en, 1'b0);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'h0010, 18'h00096, 1'b0, 2'h0);
        // Reserved command bits change nothing
        gp_chk(wgr_pkg::ADDR_COMMAND, 16'hC300, 18'h00096, 1'b0, 2'h0);
        cmpb(remote_ctrl, 1'b1);
        cmpb(gross_en, 1'b0);
        // Speed setting: enabled, disabled, out of range, top of range
        put(wgr_pkg::ADDR_SPEED, 16'hD000);
        cmp({11'h000, speed_q}, 18'h00050);
        put(wgr_pkg::ADDR_SPEED, 16'h6400);
        cmp({11'h000, speed_q}, 18'h00050);
        put(wgr_pkg::ADDR_SPEED, 16'hE500);
        cmp({11'h000, speed_q}, 18'h00050);
        put(wgr_pkg::ADDR_SPEED, 16'hE4FF);
        cmp({11'h000, speed_q}, 18'h00064);
        cmp({11'h000, accel_q}, 18'h00032);
        // Acceleration setting: same cases
        put(wgr_pkg::ADDR_ACCEL, 16'h00A0);
        cmp({11'h000, accel_q}, 18'h00020);
        put(wgr_pkg::ADDR_ACCEL, 16'hFF10);
        cmp({11'h000, accel_q}, 18'h00020);
        put(wgr_pkg::ADDR_ACCEL, 16'h00E5);
        cmp({11'h000, accel_q}, 18'h00020);
        put(wgr_pkg::ADDR_ACCEL, 16'h00E4);
        cmp({11'h000, accel_q}, 18'h00064);
        cmp({11'h000, speed_q}, 18'h00064);
        // Narrow window leaves no room either side of the middle
        @(posedge clk);
        window <= 17'h00050;
        put(wgr_pkg::ADDR_COMMAND, 16'h2200);
        gp_chk(wgr_pkg::ADDR_OFFSET, 16'h0010, 18'h00000, 1'b1, 2'h3);
        give_verdict();
    end
endmodule
